// *** logic/llsm_regs.vh ***
`ifndef LLSM_REGS_VH
`define LLSM_REGS_VH

// ****************************************************************
// register map: address = {channel[1:0], register select[1:0]}
// ****************************************************************
`define LLSM_ADDR_W          4
`define LLSM_SEL_STATUS      2'h0
`define LLSM_SEL_MODE        2'h1
`define LLSM_SEL_LCFG        2'h2
`define LLSM_SEL_RXCFG       2'h3
`define LLSM_NUM_CH          2'h3

// ****************************************************************
// field positions
// ****************************************************************
`define LLSM_ST_LOL          4
`define LLSM_ST_LOSS         3
`define LLSM_ST_ALOSS        2
`define LLSM_ST_DLOSS        1
`define LLSM_ST_DMO          0
`define LLSM_LCFG_CODEC_OFF  3
`define LLSM_LCFG_AMP_OFF    2
`define LLSM_LCFG_PULSE_OFF  1
`define LLSM_LCFG_EQ_ON      0
`define LLSM_RX_MUTE         3

// ****************************************************************
// reset values and rate codes
// ****************************************************************
`define LLSM_LCFG_RST        5'h00
`define LLSM_RXCFG_RST       5'h00
`define LLSM_MODE_RST        2'h1
`define LLSM_RATE_E3         2'h0
`define LLSM_RATE_DS3        2'h1
`define LLSM_RATE_STS1       2'h2

// ****************************************************************
// timing counts, in unit intervals of the recovered clock
// ****************************************************************
`define LLSM_ZERO_LIMIT      8'hA0
`define LLSM_WIN_LAST        5'h1F
`define LLSM_ONES_MIN        6'h0A
`define LLSM_GOOD_WINS       3'h4
`define LLSM_AMP_PERSIST     8'h20

`endif

// *** logic/llsm_amp_hyst.v ***
`timescale 1ns/10ps
`default_nettype none
`include "llsm_regs.vh"

module llsm_amp_hyst
(
  // clock and reset
  input  wire       clk_i,
  input  wire       nrst_i,
  // unit interval tick and control
  input  wire       tick_i,
  input  wire       enable_i,
  // comparator results for the selected thresholds
  input  wire       below_declare_i,
  input  wire       above_clear_i,
  // analog loss state
  output reg        loss_o
);

  reg  [7:0] persist_reg;
  wire       cond;

  // separate declare and clear comparators give the hysteresis
  assign cond = loss_o ? above_clear_i : below_declare_i;

  // ****************************************************************
  // persistence filter, keeps assert and release within 10..255 UI
  // ****************************************************************
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      persist_reg <= 8'h00;
      loss_o      <= 1'b0;
    end
    else if (!enable_i)
    begin
      persist_reg <= 8'h00; // RL12
      loss_o      <= 1'b0;  // RL12
    end
    else if (tick_i)
    begin
      if (!cond)
        persist_reg <= 8'h00;
      else if (persist_reg == `LLSM_AMP_PERSIST - 8'h01)
      begin
        persist_reg <= 8'h00;
        loss_o      <= ~loss_o; // RL4 RL5 RL6 RL8 RL9
      end
      else
        persist_reg <= persist_reg + 8'h01;
    end
  end

endmodule
`default_nettype wire

// *** logic/llsm_pulse_det.v ***
`timescale 1ns/10ps
`default_nettype none
`include "llsm_regs.vh"

module llsm_pulse_det
(
  // clock and reset
  input  wire       clk_i,
  input  wire       nrst_i,
  // unit interval tick, received bit and control
  input  wire       tick_i,
  input  wire       bit_one_i,
  input  wire       enable_i,
  // digital loss state
  output reg        loss_o
);

  reg  [7:0] zrun_reg;
  reg  [4:0] win_reg;
  reg  [5:0] ones_reg;
  reg  [2:0] good_reg;
  wire [5:0] ones_next;
  wire       win_good;

  assign ones_next = ones_reg + {5'h00, bit_one_i};
  assign win_good  = (ones_next >= `LLSM_ONES_MIN);

  // ****************************************************************
  // zero run declare, density windows clear
  // ****************************************************************
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      zrun_reg <= 8'h00;
      win_reg  <= 5'h00;
      ones_reg <= 6'h00;
      good_reg <= 3'h0;
      loss_o   <= 1'b0; // RL22
    end
    else if (!enable_i)
    begin
      zrun_reg <= 8'h00;
      win_reg  <= 5'h00;
      ones_reg <= 6'h00;
      good_reg <= 3'h0;
      loss_o   <= 1'b0; // RL16
    end
    else if (tick_i)
    begin
      // saturating count of consecutive zeros
      if (bit_one_i)
        zrun_reg <= 8'h00;
      else if (zrun_reg != 8'hFF)
        zrun_reg <= zrun_reg + 8'h01;
      if (!loss_o)
      begin
        win_reg  <= 5'h00;
        ones_reg <= 6'h00;
        good_reg <= 3'h0;
        if (!bit_one_i && zrun_reg == `LLSM_ZERO_LIMIT - 8'h01)
          loss_o <= 1'b1; // RL13 RL22
      end
      else
      begin
        win_reg <= win_reg + 5'h01;
        if (win_reg == `LLSM_WIN_LAST)
        begin
          ones_reg <= 6'h00;
          if (!win_good)
            good_reg <= 3'h0;
          else if (good_reg == `LLSM_GOOD_WINS - 3'h1)
            loss_o <= 1'b0; // RL14
          else
            good_reg <= good_reg + 3'h1;
        end
        else
          ones_reg <= ones_next;
      end
    end
  end

endmodule
`default_nettype wire

// *** logic/llsm_monitor.v ***
// Summary of operation
// RL1: loss found drives pin high, status one
// RL2: signal restored drives pin low, status zero
// RL3: watch amplitude and pulse count per channel
// RL4: E3 declares at -35dB, clears at -15dB
// RL5: E3 declare within 10 to 255 UI
// RL6: E3 clear within 10 to 255 UI
// RL7: DS3/STS-1 loss is analog OR digital
// RL8: analog declare threshold by rate, equalizer, pin
// RL9: analog clear threshold by rate and equalizer
// RL10: status holds lock, loss, analog, digital, monitor
// RL11: analog status bit shows current analog loss
// RL12: line config D2 disables amplitude detector
// RL13: digital loss after 160 consecutive zeros
// RL14: clear after four good 32-bit windows
// RL15: digital status bit shows current digital loss
// RL16: line config D1 disables pulse detector
// RL17: both detectors off means never loss
// RL18: mute forces both rails zero during loss
// RL19: global pin mutes all channels in pin mode
// RL20: receive config D3 mutes one channel in host mode
// RL21: line config D0 enables equalizer, picks thresholds
// RL22: fixed zero limit, loss cleared at reset
`timescale 1ns/10ps
`default_nettype none
`include "llsm_regs.vh"

module llsm_monitor
(
  // clock and reset
  input  wire                       clk_i,
  input  wire                       nrst_i,
  // register port
  input  wire [`LLSM_ADDR_W-1:0]    addr_i,
  input  wire [4:0]                 wdata_i,
  input  wire                       wr_i,
  input  wire                       rd_i,
  output reg  [4:0]                 rdata_o,
  // global pins
  input  wire                       host_mode_i,
  input  wire                       mute_on_loss_global_pin_i,
  input  wire                       amplitude_threshold_select_i,
  // recovered line per channel
  input  wire [2:0]                 recovered_clock_i,
  input  wire [2:0]                 recovered_positive_rail_i,
  input  wire [2:0]                 recovered_negative_rail_i,
  // analog comparators and other receiver flags per channel
  input  wire [2:0]                 amp_below_declare_i,
  input  wire [2:0]                 amp_above_clear_i,
  input  wire [2:0]                 clock_lock_lost_i,
  input  wire [2:0]                 drive_monitor_flag_i,
  // threshold code to the analog front end, per channel
  output reg  [11:0]                amp_thr_code_o,
  // loss indication and muted rails per channel
  output reg  [2:0]                 signal_loss_indication_o,
  output reg  [2:0]                 rx_positive_rail_o,
  output reg  [2:0]                 rx_negative_rail_o
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // per channel: clock, pos, neg, below, above, lol, dmo; then 3 globals
  wire [23:0] async_in;
  reg  [23:0] meta_reg;
  reg  [23:0] sync_reg;

  assign async_in = {host_mode_i, mute_on_loss_global_pin_i,
                     amplitude_threshold_select_i,
                     drive_monitor_flag_i, clock_lock_lost_i,
                     amp_above_clear_i, amp_below_declare_i,
                     recovered_negative_rail_i, recovered_positive_rail_i,
                     recovered_clock_i};

  // two stages before any logic sees a pin
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_reg <= 24'h000000;
      sync_reg <= 24'h000000;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  wire [2:0] s_clk;
  wire [2:0] s_pos;
  wire [2:0] s_neg;
  wire [2:0] s_below;
  wire [2:0] s_above;
  wire [2:0] s_lol;
  wire [2:0] s_dmo;
  wire       s_thr_sel;
  wire       s_glob_mute;
  wire       s_host;

  assign s_clk       = sync_reg[2:0];
  assign s_pos       = sync_reg[5:3];
  assign s_neg       = sync_reg[8:6];
  assign s_below     = sync_reg[11:9];
  assign s_above     = sync_reg[14:12];
  assign s_lol       = sync_reg[17:15];
  assign s_dmo       = sync_reg[20:18];
  assign s_thr_sel   = sync_reg[21];
  assign s_glob_mute = sync_reg[22];
  assign s_host      = sync_reg[23];

  // ****************************************************************
  // register decode
  // ****************************************************************
  wire [1:0] a_ch;
  wire [1:0] a_sel;
  wire       a_valid;

  assign a_ch    = addr_i[3:2];
  assign a_sel   = addr_i[1:0];
  assign a_valid = (a_ch < `LLSM_NUM_CH);

  // per channel state collected for the read mux
  wire [14:0] status_vec;
  wire [14:0] lcfg_vec;
  wire [14:0] rxcfg_vec;
  wire [5:0]  mode_vec;

  // ****************************************************************
  // per channel monitor
  // ****************************************************************
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1)
    begin : g_ch
      reg  [4:0] lcfg_reg;
      reg  [4:0] rxcfg_reg;
      reg  [1:0] mode_reg;
      reg        clk_prev_reg;
      reg        bit_pos_reg;
      reg        bit_neg_reg;
      wire       tick;
      wire       wr_here;
      wire       ana_loss;
      wire       dig_loss;
      wire       loss_now;
      wire       mute_en;
      wire       mute_now;

      // a rising edge of the sampled recovered clock marks one UI
      assign tick    = s_clk[ch] & ~clk_prev_reg;
      assign wr_here = wr_i & a_valid & (a_ch == ch);

      // configuration written by software
      always @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          lcfg_reg  <= `LLSM_LCFG_RST;
          rxcfg_reg <= `LLSM_RXCFG_RST;
          mode_reg  <= `LLSM_MODE_RST;
        end
        else if (wr_here)
        begin
          case (a_sel)
            `LLSM_SEL_LCFG:  lcfg_reg  <= {1'b0, wdata_i[3:0]}; // RL12 RL16 RL21
            `LLSM_SEL_RXCFG: rxcfg_reg <= {wdata_i[4:1], 1'b0}; // RL20
            `LLSM_SEL_MODE:  mode_reg  <= wdata_i[1:0];
            default:         mode_reg  <= mode_reg;
          endcase
        end
      end

      // sample the rails on the recovered clock rising edge
      always @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          clk_prev_reg <= 1'b0;
          bit_pos_reg  <= 1'b0;
          bit_neg_reg  <= 1'b0;
        end
        else
        begin
          clk_prev_reg <= s_clk[ch];
          if (tick)
          begin
            bit_pos_reg <= s_pos[ch];
            bit_neg_reg <= s_neg[ch];
          end
        end
      end

      // amplitude detector, thresholds chosen by the front end code
      llsm_amp_hyst u_amp
      (
        .clk_i           (clk_i),
        .nrst_i          (nrst_i),
        .tick_i          (tick),
        .enable_i        (~lcfg_reg[`LLSM_LCFG_AMP_OFF]),
        .below_declare_i (s_below[ch]),
        .above_clear_i   (s_above[ch]),
        .loss_o          (ana_loss)
      ); // RL3 RL12

      // pulse detector, a one is a mark on either rail
      llsm_pulse_det u_pulse
      (
        .clk_i     (clk_i),
        .nrst_i    (nrst_i),
        .tick_i    (tick),
        .bit_one_i (s_pos[ch] | s_neg[ch]),
        .enable_i  (~lcfg_reg[`LLSM_LCFG_PULSE_OFF]),
        .loss_o    (dig_loss)
      ); // RL3 RL16

      // overall loss; with both detectors off neither can assert
      assign loss_now = ana_loss | dig_loss; // RL7 RL17

      // mute source: register in host mode, global pin otherwise
      assign mute_en  = s_host ? rxcfg_reg[`LLSM_RX_MUTE] : s_glob_mute; // RL19 RL20
      assign mute_now = mute_en & loss_now;

      // registered pins; muted rails drop to zero during loss
      always @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          signal_loss_indication_o[ch] <= 1'b0;
          rx_positive_rail_o[ch]       <= 1'b0;
          rx_negative_rail_o[ch]       <= 1'b0;
          amp_thr_code_o[ch*4+3:ch*4]  <= 4'h0;
        end
        else
        begin
          signal_loss_indication_o[ch] <= loss_now; // RL1 RL2
          rx_positive_rail_o[ch]       <= bit_pos_reg & ~mute_now; // RL18
          rx_negative_rail_o[ch]       <= bit_neg_reg & ~mute_now; // RL18
          amp_thr_code_o[ch*4+3:ch*4]  <= {mode_reg,
                                           lcfg_reg[`LLSM_LCFG_EQ_ON],
                                           s_thr_sel}; // RL4 RL8 RL9 RL21
        end
      end

      // live status word
      assign status_vec[ch*5+4:ch*5] = {s_lol[ch], loss_now, ana_loss,
                                        dig_loss, s_dmo[ch]}; // RL10 RL11 RL15
      assign lcfg_vec[ch*5+4:ch*5]   = lcfg_reg;
      assign rxcfg_vec[ch*5+4:ch*5]  = rxcfg_reg;
      assign mode_vec[ch*2+1:ch*2]   = mode_reg;
    end
  endgenerate

  // ****************************************************************
  // read data, valid in the cycle after the read strobe only
  // ****************************************************************
  reg [4:0] rd_word;

  // unmapped channels read as zero
  always @*
  begin
    rd_word = 5'h00;
    if (a_valid)
    begin
      case (a_sel)
        `LLSM_SEL_STATUS: rd_word = status_vec[a_ch*5 +: 5];
        `LLSM_SEL_MODE:   rd_word = {3'h0, mode_vec[a_ch*2 +: 2]};
        `LLSM_SEL_LCFG:   rd_word = lcfg_vec[a_ch*5 +: 5];
        `LLSM_SEL_RXCFG:  rd_word = rxcfg_vec[a_ch*5 +: 5];
        default:          rd_word = 5'h00;
      endcase
    end
  end

  // data bus returns to zero between reads
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= 5'h00;
    else if (rd_i)
      rdata_o <= rd_word;
    else
      rdata_o <= 5'h00;
  end

endmodule
`default_nettype wire

// *** tb/llsm_monitor_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "llsm_regs.vh"
// ********
// port checker
// ********
module llsm_checker
(
  // clock and reset
  input wire logic                    clk_i,
  input wire logic                    nrst_i,
  // register port
  input wire logic [`LLSM_ADDR_W-1:0] addr_i,
  input wire logic [4:0]              wdata_i,
  input wire logic                    wr_i,
  input wire logic                    rd_i,
  input wire logic [4:0]              rdata_o,
  // mute pins, line and outputs
  input wire logic                    host_mode_i,
  input wire logic                    mute_on_loss_global_pin_i,
  input wire logic [2:0]              recovered_positive_rail_i,
  input wire logic [2:0]              recovered_negative_rail_i,
  input wire logic [2:0]              amp_below_declare_i,
  input wire logic [2:0]              signal_loss_indication_o,
  input wire logic [2:0]              rx_positive_rail_o,
  input wire logic [2:0]              rx_negative_rail_o
);
  logic [1:0] off0_reg;
  wire  [2:0] act = rx_positive_rail_o | rx_negative_rail_o;
  wire  [2:0] los = signal_loss_indication_o;
  wire        mk0 = recovered_positive_rail_i[0] | recovered_negative_rail_i[0];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // shadow of channel 0 detector-off bits, the registers are not visible here
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      off0_reg <= 2'h0;
    else if (wr_i && addr_i == 4'h2)
      off0_reg <= wdata_i[2:1];

  // pin-mode mute held long enough to cross the mode synchroniser
  sequence pin_mute_s;
    (!host_mode_i && mute_on_loss_global_pin_i) [*4];
  endsequence

  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 5'h00)
    else $error("read data outside read slot");
  unmapped_rd_a: assert property ($past(rd_i) && $past(addr_i[3:2]) == 2'h3
    |-> rdata_o == 5'h00) else $error("unmapped read not zero");
  loss_or_a: assert property ($past(rd_i) && $past(addr_i[1:0]) == 2'h0
    |-> rdata_o[3] == (rdata_o[2] | rdata_o[1])) else $error("loss not or of parts");
  lcfg_rsv_a: assert property ($past(rd_i) && $past(addr_i[1:0]) == 2'h2
    |-> !rdata_o[4]) else $error("line config spare bit set");
  rxcfg_rsv_a: assert property ($past(rd_i) && $past(addr_i[1:0]) == 2'h3
    |-> !rdata_o[0]) else $error("receive config spare bit set");
  declare_delay_a: assert property ($rose(los[0])
    |-> $past(amp_below_declare_i[0] | !mk0, 10)) else $error("loss without cause");
  both_off_a: assert property (off0_reg == 2'h3 && $past(off0_reg) == 2'h3
    && $past(off0_reg, 2) == 2'h3 |-> !los[0]) else $error("loss with detectors off");
  pin_mute_a: assert property (pin_mute_s ##1 1'b1
    |-> ($past(act) & $past(los) & $past(los, 2) & los) == 3'h0)
    else $error("rails live while muted");
endmodule

bind llsm_monitor llsm_checker u_chk
(
  .clk_i,
  .nrst_i,
  .addr_i,
  .wdata_i,
  .wr_i,
  .rd_i,
  .rdata_o,
  .host_mode_i,
  .mute_on_loss_global_pin_i,
  .recovered_positive_rail_i,
  .recovered_negative_rail_i,
  .amp_below_declare_i,
  .signal_loss_indication_o,
  .rx_positive_rail_o,
  .rx_negative_rail_o
);
`default_nettype wire

// *** tb/llsm_line_src.sv ***
`timescale 1ns/10ps
`default_nettype none
// ********
// recovered line source
// ********
module llsm_line_src
(
  // stream control per channel
  input  wire logic [2:0] run_i,
  input  wire logic [2:0] marks_i,
  // recovered clock and dual-rail data
  output wire logic [2:0] rclk_o,
  output var  logic [2:0] pos_o,
  output var  logic [2:0] neg_o
);
  logic       ph = 1'b0;
  logic [2:0] sign_reg = 3'h0;
  logic       mk;

  initial
  begin
    pos_o = 3'h0;
    neg_o = 3'h0;
  end

  // 160 ns line clock; a stopped channel holds its clock low
  always #80 ph = ~ph;
  assign rclk_o = {3{ph}} & run_i;

  // rails move at the falling edge so they are settled at the rising one;
  // dense marks of alternating polarity, as a bipolar line delivers
  always @(negedge ph)
    for (int c = 0; c < 3; c++)
    begin
      mk = marks_i[c] && ($urandom % 4 != 0);
      pos_o[c] <= mk && !sign_reg[c];
      neg_o[c] <= mk && sign_reg[c];
      if (mk)
        sign_reg[c] <= ~sign_reg[c];
    end
endmodule
`default_nettype wire

// *** tb/llsm_monitor_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module llsm_monitor_bench;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [4:0]  wdata_i = 5'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        host = 1'b1;
  logic        glob = 1'b0;
  logic        thr = 1'b0;
  logic [2:0]  run = 3'h0;
  logic [2:0]  marks = 3'h0;
  logic [2:0]  below = 3'h0;
  logic [2:0]  above = 3'h7;
  logic [2:0]  lol = 3'h0;
  logic [2:0]  dmo = 3'h0;
  wire  [2:0]  rclk, pos, neg, loss, rpos, rneg;
  wire  [4:0]  rdata;
  wire  [11:0] code;
  logic [4:0]  r, d;
  logic [2:0]  act;
  int          fails = 0;
  int          n_checks = 0;
  int          n;

  always #10 clk_i = ~clk_i;

  llsm_line_src u_src (.run_i(run), .marks_i(marks), .rclk_o(rclk), .pos_o(pos), .neg_o(neg));
  llsm_monitor DUT (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o(rdata),
    .host_mode_i(host), .mute_on_loss_global_pin_i(glob), .amplitude_threshold_select_i(thr),
    .recovered_clock_i(rclk), .recovered_positive_rail_i(pos), .recovered_negative_rail_i(neg),
    .amp_below_declare_i(below), .amp_above_clear_i(above), .clock_lock_lost_i(lol),
    .drive_monitor_flag_i(dmo), .amp_thr_code_o(code), .signal_loss_indication_o(loss),
    .rx_positive_rail_o(rpos), .rx_negative_rail_o(rneg));

  // ********
  // bench tasks
  // ********
  task automatic print_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // line-rate window in ticks of 8 clocks
  function automatic logic inr(input int cyc, input int lo, input int hi);
    return cyc / 8 >= lo && cyc / 8 <= hi;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [4:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the slot after the strobe edge; take them mid slot
  // and end on a rising edge so the caller keeps driving on the clock edge
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    r = rdata;
    @(posedge clk_i);
  endtask

  task automatic wl(input int c, input logic v);
    n = 0;
    while (loss[c] !== v)
    begin
      @(posedge clk_i);
      n++;
      if (n > 4000)
      begin
        fails++;
        $display("BAD t=%0t got=%h exp=%h", $time, loss[c], v);
        print_verdict();
      end
    end
  endtask

  task automatic watch;
    act = 3'h0;
    // let a mute change cross the pin synchroniser and the rail registers
    repeat (4) @(posedge clk_i);
    repeat (200)
    begin
      @(posedge clk_i);
      act = act | rpos | rneg;
    end
  endtask

  // ********
  // main sequence
  // ********
  initial
  begin
    d = $urandom(32'h4400);
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    lol <= $urandom;
    dmo <= $urandom;
    for (int c = 0; c < 4; c++)
    begin
      d = $urandom;
      rd({c[1:0], 2'h1});
      chk(r, c < 3 ? 5'h01 : 5'h00);
      wr({c[1:0], 2'h0}, d);
      rd({c[1:0], 2'h0});
      chk(r, c < 3 ? {lol[c], 3'h0, dmo[c]} : 5'h00);
      wr({c[1:0], 2'h2}, d);
      rd({c[1:0], 2'h2});
      chk(r, c < 3 ? d & 5'h0F : 5'h00);
      wr({c[1:0], 2'h3}, ~d);
      rd({c[1:0], 2'h3});
      chk(r, c < 3 ? ~d & 5'h1E : 5'h00);
      wr({c[1:0], 2'h2}, 5'h00);
      wr({c[1:0], 2'h3}, 5'h00);
    end
    for (int k = 0; k < 3; k++)
    begin
      thr <= $urandom;
      wr(4'h1, k[4:0]);
      wr(4'h2, {4'h0, k[0]});
      repeat (4) @(posedge clk_i);
      chk(code, {2'h1, 1'b0, thr, 2'h1, 1'b0, thr, k[1:0], k[0], thr});
    end
    wr(4'h2, 5'h00);
    $display("test registers done");
    run <= 3'h7;
    marks <= 3'h7;
    repeat (400) @(posedge clk_i);
    marks[0] <= 1'b0;
    wl(0, 1'b1);
    chk(inr(n, 128, 192), 1'b1);
    rd(4'h0);
    chk(r[3:1], 3'b101);
    marks[0] <= 1'b1;
    wl(0, 1'b0);
    // windows stay aligned to the declare: three full good windows and ten
    // marks at the least, five windows at the most, counted from the restore
    chk(inr(n, 106, 160), 1'b1);
    rd(4'h0);
    chk(r[3:1], 3'b000);
    $display("test pulse loss done");
    below <= 3'h6;
    above <= 3'h1;
    wl(1, 1'b1);
    chk(inr(n, 10, 255), 1'b1);
    rd(4'h4);
    chk(r[3:1], 3'b110);
    wl(2, 1'b1);
    wr(4'h7, 5'h08);
    watch();
    chk(act[2:1], 2'b10);
    host <= 1'b0;
    glob <= 1'b1;
    watch();
    chk(act[2:1], 2'b00);
    glob <= 1'b0;
    watch();
    chk(act[2:1], 2'b11);
    host <= 1'b1;
    below[1] <= 1'b0;
    above[1] <= 1'b1;
    wl(1, 1'b0);
    chk(inr(n, 10, 255), 1'b1);
    wr(4'hA, 5'h04);
    wl(2, 1'b0);
    chk(n < 8, 1'b1);
    $display("test amplitude loss done");
    wr(4'h2, 5'h02);
    marks[0] <= 1'b0;
    repeat (2000) @(posedge clk_i);
    chk(loss[0], 1'b0);
    below[0] <= 1'b1;
    above[0] <= 1'b0;
    wl(0, 1'b1);
    chk(inr(n, 10, 255), 1'b1);
    wr(4'h2, 5'h06);
    wl(0, 1'b0);
    repeat (2000) @(posedge clk_i);
    chk(loss[0], 1'b0);
    $display("test detector off done");
    print_verdict();
  end
endmodule
`default_nettype wire
